// [cmal_pkg.sv]
package cmal_pkg;

    // ****************************************************************
    // address widths and memory geometry
    // ****************************************************************
    localparam int CMAL_PC_W = 21;
    localparam int CMAL_WORD_W = 20;
    localparam int CMAL_DADDR_W = 12;
    localparam int CMAL_BANK_COUNT = 16;
    localparam int CMAL_BANK_BYTES = 256;
    localparam logic [19:0] CMAL_PC_RST = 20'h00000;
    localparam logic [19:0] CMAL_WORD_STEP = 20'h00001;

    // ****************************************************************
    // data memory map
    // ****************************************************************
    localparam logic [7:0] CMAL_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] CMAL_ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] CMAL_ACCESS_HIGH_BANK = 4'hF;
    localparam logic [11:0] CMAL_SPECIAL_BASE = 12'hF38;
    localparam logic [11:0] CMAL_SPECIAL_TOP = 12'hFFF;
    localparam logic [11:0] CMAL_BANK_PTR_ADDR = 12'hFE0;
    localparam logic [11:0] CMAL_PC_LOW_ADDR = 12'hFF9;
    // one bit per bank, set where RAM is fitted
    localparam logic [15:0] CMAL_BANK_IMPL = 16'h800F;
    localparam logic [7:0] CMAL_BANK_PTR_RST = 8'h00;
    localparam logic [3:0] CMAL_BANK_PTR_PAD = 4'h0;

    // ****************************************************************
    // instruction encodings
    // ****************************************************************
    localparam logic [3:0] CMAL_SECOND_TAG = 4'hF;
    localparam logic [7:0] CMAL_OP_GOTO = 8'hEF;
    localparam logic [6:0] CMAL_OP_CALL = 7'h76;
    localparam logic [9:0] CMAL_OP_LFSR = 10'h3B8;
    localparam logic [3:0] CMAL_OP_FULL_MOVE = 4'hC;
    localparam logic [4:0] CMAL_OP_BRA = 5'h1A;
    localparam logic [11:0] CMAL_OP_LOAD_BANK = 12'h010;
    localparam logic [6:0] CMAL_OP_MOVWF = 7'h37;
    localparam logic [6:0] CMAL_OP_TEST_SKIP = 7'h33;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        CMAL_ST_RUN = 2'b00,
        CMAL_ST_WORD2 = 2'b01,
        CMAL_ST_DROP = 2'b11
    } cmal_state_t;

    typedef enum logic [1:0] {
        CMAL_PEND_GOTO = 2'b00,
        CMAL_PEND_CALL = 2'b01,
        CMAL_PEND_LFSR = 2'b10,
        CMAL_PEND_FULL_MOVE = 2'b11
    } cmal_pend_t;

    typedef struct packed {
        logic we;
        logic [11:0] waddr;
        logic [7:0] wdata;
        logic [11:0] raddr;
    } cmal_dm_req_t;

    // ****************************************************************
    // address helpers
    // ****************************************************************
    function automatic logic [11:0] cmal_access_addr(
        input logic a,
        input logic [7:0] f,
        input logic [7:0] bank_reg
    );
        if (a) begin
            return {bank_reg[3:0], f};
        end else if (f < CMAL_ACCESS_SPLIT) begin
            return {CMAL_ACCESS_LOW_BANK, f};
        end else begin
            return {CMAL_ACCESS_HIGH_BANK, f};
        end
    endfunction : cmal_access_addr

    function automatic logic cmal_bank_impl(input logic [11:0] addr);
        return (addr >= CMAL_SPECIAL_BASE) || CMAL_BANK_IMPL[addr[11:8]];
    endfunction : cmal_bank_impl

endpackage : cmal_pkg

// [cmal_dm_port.sv]
`timescale 1ns/1ps
module cmal_dm_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // request from the core
    input cmal_pkg::cmal_dm_req_t req,
    input wire logic [7:0] bank_pointer,
    // data memory side
    output cmal_pkg::cmal_dm_req_t mem_req,
    input wire logic [7:0] mem_rdata,
    // results
    output logic [7:0] rdata,
    output logic bank_wr,
    output logic pc_wr
);
    import cmal_pkg::*;

    logic own_reg;

    always_comb begin
        if (req.raddr == CMAL_BANK_PTR_ADDR) begin
            rdata = bank_pointer;
        end else if (!cmal_bank_impl(req.raddr)) begin
            rdata = 8'h00;
        end else begin
            rdata = mem_rdata;
        end
    end

    // write to program counter low byte
    assign pc_wr = req.we && (req.waddr == CMAL_PC_LOW_ADDR);
    assign bank_wr = req.we && (req.waddr == CMAL_BANK_PTR_ADDR);
    assign own_reg = pc_wr || bank_wr;

    always_comb begin
        mem_req = req;
        mem_req.we = req.we && !own_reg && cmal_bank_impl(req.waddr);
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    unimpl_read_zero_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        !cmal_bank_impl(req.raddr) |-> (rdata == 8'h00))
        else $error("read of missing bank not zero");
    unimpl_write_drop_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (req.we && !cmal_bank_impl(req.waddr)) |-> !mem_req.we)
        else $error("write to missing bank reached memory");
    special_area_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (req.raddr >= CMAL_SPECIAL_BASE) && (req.raddr != CMAL_BANK_PTR_ADDR)
        |-> (rdata == mem_rdata))
        else $error("special register area not passed through");

endmodule : cmal_dm_port

// [cmal_core.sv]
// Operation
// - program memory is byte addressed; words sit at even addresses
// - program counter steps two bytes; its lowest bit always reads zero
// - absolute jump and call targets load as word address into bits 20:1
// - relative branch offset counts single-word instructions, not bytes
// - four two-word instructions; second word is 1111 plus 12 literal bits
// - second word right after its first supplies that instruction's literal
// - a tagged word executed on its own behaves as a no-operation
// - data addresses are 12 bits: 16 banks of 256 bytes
// - reads of unimplemented data locations return zero
// - banked address is bank pointer on top, 8-bit operand below
// - upper four bank pointer bits read zero and ignore writes
// - a literal instruction loads the bank pointer directly
// - missing banks drop writes, read zero; status flag still updates
// - full address move uses both encoded 12-bit addresses, no bank pointer
// - access map: 00h-5Fh to bank 0, 60h-FFh to bank 15
// - select bit one uses bank pointer, zero uses the access map
// - access map operation completes in one instruction cycle
// - banked write to F9h in bank 0Fh alters program flow
// - single-word instructions take one cycle, two-word ones two; each flow change adds one flush cycle
// - special registers fill F38h to FFFh in bank 15
`timescale 1ns/1ps
module cmal_core (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // program memory
    output logic [20:0] PM_ADDR,
    input wire logic [15:0] PM_DATA,
    // data memory
    output cmal_pkg::cmal_dm_req_t DM_REQ,
    input wire logic [7:0] DM_RDATA,
    // working register from the datapath
    input wire logic [7:0] W_DATA,
    // core state
    output logic [7:0] BANK_POINTER,
    output logic ZERO_FLAG,
    // pointer literal load
    output logic PTR_LOAD,
    output logic [1:0] PTR_SEL,
    output logic [11:0] PTR_VALUE,
    // subroutine call
    output logic CALL_PUSH,
    output logic [20:0] RETURN_ADDR
);
    import cmal_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    cmal_state_t state;
    cmal_state_t next_state;
    cmal_pend_t pend;
    logic [19:0] fetch_word;
    logic [19:0] next_fetch_word;
    logic [15:0] first_word;
    logic [7:0] bank_pointer;

    // ****************************************************************
    // decode
    // ****************************************************************
    logic [15:0] word;
    logic is_second;
    logic normal;
    logic do_second;
    logic is_goto;
    logic is_call;
    logic is_lfsr;
    logic is_full_move;
    logic is_bra;
    logic is_load_bank;
    logic is_movwf;
    logic is_tst;
    logic is_first;
    logic do_jump;
    logic do_bra;
    logic do_skip;
    logic redirect;
    logic [19:0] jump_target;
    logic [19:0] bra_target;
    logic [11:0] op_addr;
    cmal_dm_req_t raw_req;
    logic [7:0] rdata;
    logic bank_wr;
    logic pc_wr;

    assign word = PM_DATA;
    assign is_second = (word[15:12] == CMAL_SECOND_TAG);
    // lone tagged word decodes as nothing
    assign normal = (state == CMAL_ST_RUN ||
                     (state == CMAL_ST_WORD2 && !is_second)) && !is_second;
    assign do_second = (state == CMAL_ST_WORD2) && is_second;

    assign is_goto = normal && (word[15:8] == CMAL_OP_GOTO);
    assign is_call = normal && (word[15:9] == CMAL_OP_CALL);
    assign is_lfsr = normal && (word[15:6] == CMAL_OP_LFSR);
    assign is_full_move = normal && (word[15:12] == CMAL_OP_FULL_MOVE);
    assign is_first = is_goto || is_call || is_lfsr || is_full_move;
    assign is_bra = normal && (word[15:11] == CMAL_OP_BRA);
    assign is_load_bank = normal && (word[15:4] == CMAL_OP_LOAD_BANK);
    assign is_movwf = normal && (word[15:9] == CMAL_OP_MOVWF);
    assign is_tst = normal && (word[15:9] == CMAL_OP_TEST_SKIP);

    assign jump_target = {word[11:0], first_word[7:0]};
    assign do_jump = do_second &&
                     (pend == CMAL_PEND_GOTO || pend == CMAL_PEND_CALL);
    // offset in words from the next instruction
    assign bra_target = fetch_word + {{9{word[10]}}, word[10:0]};
    assign do_bra = is_bra;
    assign do_skip = is_tst && (rdata == 8'h00);
    assign redirect = do_jump || do_bra || pc_wr;

    // select bit picks banked or access map
    assign op_addr = cmal_access_addr(word[8], word[7:0], bank_pointer);

    // ****************************************************************
    // data memory request
    // ****************************************************************
    always_comb begin
        raw_req = '0;
        if (do_second && pend == CMAL_PEND_FULL_MOVE) begin
            raw_req.raddr = first_word[11:0];
            raw_req.waddr = word[11:0];
            raw_req.we = 1'b1;
            raw_req.wdata = rdata;
        end else if (is_movwf) begin
            raw_req.waddr = op_addr;
            raw_req.we = 1'b1;
            raw_req.wdata = W_DATA;
        end else if (is_tst) begin
            // mapped read in the same cycle
            raw_req.raddr = op_addr;
        end
    end

    cmal_dm_port u_dm_port (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .req(raw_req),
        .bank_pointer(bank_pointer),
        .mem_req(DM_REQ),
        .mem_rdata(DM_RDATA),
        .rdata(rdata),
        .bank_wr(bank_wr),
        .pc_wr(pc_wr)
    );

    // ****************************************************************
    // program counter
    // ****************************************************************
    always_comb begin
        if (do_jump) begin
            next_fetch_word = jump_target;
        end else if (do_bra) begin
            next_fetch_word = bra_target;
        end else if (pc_wr) begin
            next_fetch_word = {fetch_word[19:7], raw_req.wdata[7:1]};
        end else begin
            next_fetch_word = fetch_word + CMAL_WORD_STEP;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            fetch_word <= CMAL_PC_RST;
        end else begin
            fetch_word <= next_fetch_word;
        end
    end

    // even byte address for each word
    assign PM_ADDR = {fetch_word, 1'b0};

    // ****************************************************************
    // sequencing
    // ****************************************************************
    always_comb begin
        case (state)
            CMAL_ST_RUN, CMAL_ST_WORD2: begin
                // flush one word on any flow change
                if (redirect || do_skip) begin
                    next_state = CMAL_ST_DROP;
                end else if (is_first) begin
                    next_state = CMAL_ST_WORD2;
                end else begin
                    next_state = CMAL_ST_RUN;
                end
            end
            CMAL_ST_DROP: begin
                next_state = CMAL_ST_RUN;
            end
            default: begin
                next_state = CMAL_ST_DROP;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= CMAL_ST_DROP;
        end else begin
            state <= next_state;
        end
    end

    // hold the first word for its partner
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            first_word <= 16'h0000;
            pend <= CMAL_PEND_GOTO;
        end else if (is_first) begin
            first_word <= word;
            if (is_goto) begin
                pend <= CMAL_PEND_GOTO;
            end else if (is_call) begin
                pend <= CMAL_PEND_CALL;
            end else if (is_lfsr) begin
                pend <= CMAL_PEND_LFSR;
            end else begin
                pend <= CMAL_PEND_FULL_MOVE;
            end
        end
    end

    // ****************************************************************
    // bank pointer and status
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bank_pointer <= CMAL_BANK_PTR_RST;
        end else if (is_load_bank) begin
            bank_pointer <= {CMAL_BANK_PTR_PAD, word[3:0]};
        end else if (bank_wr) begin
            bank_pointer <= {CMAL_BANK_PTR_PAD, raw_req.wdata[3:0]};
        end
    end

    assign BANK_POINTER = bank_pointer;

    // flag follows the read even from a missing bank
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ZERO_FLAG <= 1'b0;
        end else if (is_tst) begin
            ZERO_FLAG <= (rdata == 8'h00);
        end
    end

    // ****************************************************************
    // two-word results
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PTR_LOAD <= 1'b0;
            PTR_SEL <= 2'b00;
            PTR_VALUE <= 12'h000;
        end else begin
            PTR_LOAD <= do_second && (pend == CMAL_PEND_LFSR);
            if (do_second && pend == CMAL_PEND_LFSR) begin
                PTR_SEL <= first_word[5:4];
                PTR_VALUE <= {first_word[3:0], word[7:0]};
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CALL_PUSH <= 1'b0;
            RETURN_ADDR <= 21'h00000;
        end else begin
            CALL_PUSH <= do_second && (pend == CMAL_PEND_CALL);
            if (do_second && pend == CMAL_PEND_CALL) begin
                RETURN_ADDR <= {fetch_word, 1'b0};
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    pc_even_addr_a: assert property (PM_ADDR[0] == 1'b0)
        else $error("fetch address odd");
    pc_step_two_a: assert property (!redirect |=>
        PM_ADDR == $past(PM_ADDR) + 21'd2)
        else $error("fetch did not step two bytes");
    jump_target_a: assert property (do_jump |=>
        PM_ADDR == {$past(word[11:0]), $past(first_word[7:0]), 1'b0})
        else $error("jump target wrong");
    branch_words_a: assert property (do_bra |=>
        PM_ADDR[20:1] == $past(fetch_word) +
        {{9{$past(word[10])}}, $past(word[10:0])})
        else $error("branch offset not in words");
    lone_second_nop_a: assert property (
        (state != CMAL_ST_WORD2 && is_second) |->
        (!DM_REQ.we && !redirect) ##1 (!PTR_LOAD && !CALL_PUSH))
        else $error("lone second word had an effect");
    full_move_addr_a: assert property (
        (do_second && pend == CMAL_PEND_FULL_MOVE) |->
        (raw_req.we && raw_req.waddr == word[11:0] &&
         raw_req.raddr == first_word[11:0]))
        else $error("full address move addresses wrong");
    bank_upper_zero_a: assert property (BANK_POINTER[7:4] == 4'h0)
        else $error("bank pointer upper bits set");
    bank_literal_a: assert property (is_load_bank |=>
        BANK_POINTER == {4'h0, $past(word[3:0])})
        else $error("bank literal not loaded");
    access_map_a: assert property ((normal && !word[8]) |->
        op_addr[11:8] == ((word[7:0] < 8'h60) ? 4'h0 : 4'hF))
        else $error("access map bank wrong");
    banked_addr_a: assert property ((normal && word[8]) |->
        op_addr == {BANK_POINTER[3:0], word[7:0]})
        else $error("banked address wrong");
    pc_low_redirect_a: assert property (pc_wr |=>
        PM_ADDR[7:1] == $past(raw_req.wdata[7:1]))
        else $error("low byte write did not redirect");
    map_write_now_a: assert property (
        (is_movwf && !word[8] && op_addr != CMAL_BANK_PTR_ADDR &&
         op_addr != CMAL_PC_LOW_ADDR) |->
        (DM_REQ.we && DM_REQ.waddr == op_addr))
        else $error("mapped write not issued in its cycle");
    flush_one_a: assert property ((redirect || do_skip) |=>
        (state == CMAL_ST_DROP) ##1 (state == CMAL_ST_RUN))
        else $error("flush not one cycle");

    two_word_cov: cover property (is_first ##1 do_second);
    skip_lone_cov: cover property (do_skip ##1 is_first ##1 is_second);
    pc_low_write_cov: cover property (pc_wr);
    high_access_cov: cover property (is_tst && !word[8] && word[7] && word[6]);

endmodule : cmal_core

// [cmal_mem_model.sv]
`timescale 1ns/1ps
module cmal_mem_model (
    // clock
    input wire logic clk,
    // program memory
    input wire logic [20:0] pm_addr,
    output logic [15:0] pm_data,
    // data memory
    input cmal_pkg::cmal_dm_req_t dm_req,
    output logic [7:0] dm_rdata
);
    import cmal_pkg::*;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [15:0] rom [0:255];
    logic [7:0] ram [0:4095];

    initial begin
        for (int i = 0; i < 256; i++) begin
            rom[i] = 16'h0000;
        end
        for (int i = 0; i < 4096; i++) begin
            ram[i] = 8'h00;
        end
    end

    // ****************************************************************
    // program fetch, one cycle latency
    // ****************************************************************
    // word indexed fetch
    always @(posedge clk) begin
        pm_data <= rom[pm_addr[8:1]];
    end

    // ****************************************************************
    // data access: read in the same cycle, write on the edge
    // ****************************************************************
    assign dm_rdata = ram[dm_req.raddr];

    always @(posedge clk) begin
        if (dm_req.we === 1'b1) begin
            ram[dm_req.waddr] <= dm_req.wdata;
        end
    end
endmodule : cmal_mem_model

// [tb_cmal_core.sv]
`timescale 1ns/1ps
module tb_cmal_core;
    import cmal_pkg::*;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] w_data = 8'hA3;
    logic [20:0] pm_addr;
    logic [15:0] pm_data;
    cmal_dm_req_t dm_req;
    logic [7:0] dm_rdata;
    logic [7:0] bank_pointer;
    logic zero_flag;
    logic ptr_load;
    logic [1:0] ptr_sel;
    logic [11:0] ptr_value;
    logic call_push;
    logic [20:0] return_addr;
    int num_errors = 0;
    int comparisons = 0;
    int call_cnt = 0;
    int ptr_cnt = 0;

    always #20 core_clk = ~core_clk;

    cmal_core dut (
        .CORE_CLK(core_clk),
        .RST_B(rst_b),
        .PM_ADDR(pm_addr),
        .PM_DATA(pm_data),
        .DM_REQ(dm_req),
        .DM_RDATA(dm_rdata),
        .W_DATA(w_data),
        .BANK_POINTER(bank_pointer),
        .ZERO_FLAG(zero_flag),
        .PTR_LOAD(ptr_load),
        .PTR_SEL(ptr_sel),
        .PTR_VALUE(ptr_value),
        .CALL_PUSH(call_push),
        .RETURN_ADDR(return_addr)
    );

    cmal_mem_model mem (
        .clk(core_clk),
        .pm_addr(pm_addr),
        .pm_data(pm_data),
        .dm_req(dm_req),
        .dm_rdata(dm_rdata)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string name, input logic [20:0] exp,
                         input logic [20:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic load(input int waddr, input logic [15:0] word);
        mem.rom[waddr] = word;
    endtask : load

    task automatic finish_test;
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // ****************************************************************
    // per-cycle monitor
    // ****************************************************************
    always @(negedge core_clk) begin
        if (rst_b) begin
            check("fetch lsb", 21'h0, {20'h0, pm_addr[0]});
            check("bank upper", 21'h0, {17'h0, bank_pointer[7:4]});
            if (call_push === 1'b1) begin
                call_cnt++;
                check("call target", 21'h80, pm_addr);
            end
            if (ptr_load === 1'b1) begin
                ptr_cnt++;
                check("ptr value", 21'h5AB, {9'h0, ptr_value});
            end
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        // let the memory model clear itself first
        #1;
        load(0, 16'h6EE0);
        load(1, 16'h6F50);
        load(2, 16'h0102);
        load(3, 16'h6F10);
        load(4, 16'h6E10);
        load(5, 16'h6E70);
        load(6, 16'h0104);
        load(7, 16'h6F20);
        load(8, 16'h6720);
        load(9, 16'hC210);
        load(10, 16'hF330);
        load(11, 16'hC210);
        load(12, 16'hF331);
        load(13, 16'h6610);
        load(14, 16'hEE25);
        load(15, 16'hF0AB);
        load(16, 16'hEC40);
        load(17, 16'hF000);
        load(64, 16'hD005);
        load(70, 16'h010F);
        load(71, 16'hEF54);
        load(72, 16'hF000);
        load(81, 16'h0100);
        load(84, 16'h6FF9);
        load(85, 16'h6E30);
        load(86, 16'hD7FF);
        mem.ram[12'h420] = 8'h55;
        mem.ram[12'h330] = 8'h11;
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (200) @(negedge core_clk);
        check("ram 350", 21'hA3, {13'h0, mem.ram[12'h350]});
        check("ram 210", 21'hA3, {13'h0, mem.ram[12'h210]});
        check("ram 010", 21'hA3, {13'h0, mem.ram[12'h010]});
        check("ram F70", 21'hA3, {13'h0, mem.ram[12'hF70]});
        check("ram 420", 21'h55, {13'h0, mem.ram[12'h420]});
        check("ram 330", 21'h11, {13'h0, mem.ram[12'h330]});
        check("ram 331", 21'hA3, {13'h0, mem.ram[12'h331]});
        check("ptr sel", 21'h2, {19'h0, ptr_sel});
        check("ptr count", 21'h1, 21'(ptr_cnt));
        check("call count", 21'h1, 21'(call_cnt));
        check("return addr", 21'h24, return_addr);
        check("ram 0F9", 21'hA3, {13'h0, mem.ram[12'h0F9]});
        check("ram 030", 21'hA3, {13'h0, mem.ram[12'h030]});
        check("zero flag", 21'h0, {20'h0, zero_flag});
        check("bank ptr", 21'h0, {13'h0, bank_pointer});
        check("ram 270", 21'h0, {13'h0, mem.ram[12'h270]});
        check("ram 050", 21'h0, {13'h0, mem.ram[12'h050]});
        check("ram FE0", 21'h0, {13'h0, mem.ram[12'hFE0]});
        finish_test();
    end

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        #(1000 * 40);
        num_errors++;
        finish_test();
    end
endmodule : tb_cmal_core
